// ### shared/occ_defs.vh
`ifndef OCC_DEFS_VH
`define OCC_DEFS_VH

// Register offsets (byte addresses, one word each)
`define OCC_ADDR_CTRL     8'h00
`define OCC_ADDR_STATUS   8'h04
`define OCC_ADDR_KEYEV    8'h08
`define OCC_ADDR_MENUSEL  8'h0c
`define OCC_ADDR_EVENTS   8'h10
`define OCC_ADDR_FACIL    8'h14

// Control register fields
`define OCC_CTRL_EXT_ASSIST   0
`define OCC_CTRL_PKB_EMUL     1
`define OCC_CTRL_COPY_PRINTER 2
`define OCC_CTRL_RSF_ACTIVE   3

// Facility register fields
`define OCC_FAC_DISKETTE  0
`define OCC_FAC_COMM      1
`define OCC_FAC_CARD_UNIT 2

// Event flag bits (sticky, write one to clear)
`define OCC_EV_ATTN       0
`define OCC_EV_EXT_INT    1
`define OCC_EV_CANCEL_ID  2
`define OCC_EV_RSF_END    3
`define OCC_EV_COMM_REQ   4
`define OCC_EV_SP_MAINT   5
`define OCC_EV_COPY       6
`define OCC_EV_STOP_REQ   7
`define OCC_EV_FIELD_ERS  8
`define OCC_EV_MBUF_CLR   9
`define OCC_EV_PFKEY      10
`define OCC_EV_MENU       11
`define OCC_EV_WIDTH      12

// Key codes on the 7-bit key scan bus
`define OCC_KEY_MENU      7'h01
`define OCC_KEY_TOGGLE    7'h02
`define OCC_KEY_CANCEL    7'h03
`define OCC_KEY_INTR      7'h04
`define OCC_KEY_ERASE     7'h05
`define OCC_KEY_REQUEST   7'h06
`define OCC_KEY_COPY      7'h07
`define OCC_KEY_STOP      7'h08
`define OCC_KEY_PF_FIRST  7'h10
`define OCC_KEY_PF_LAST   7'h1b
`define OCC_KEY_COUNT     7'h4b

// Menu variants
`define OCC_MENU_NONE     2'h0
`define OCC_MENU_OPER_STD 2'h1
`define OCC_MENU_OPER_EXT 2'h2
`define OCC_MENU_MAINT    2'h3

// Menu listing bits
`define OCC_LIST_STORE_STATUS 0
`define OCC_LIST_MACHINE_SAVE 1
`define OCC_LIST_DISKETTE     2
`define OCC_LIST_DEV_ADDR     3
`define OCC_LIST_COMM         4

// Single-character function codes (ASCII)
`define OCC_FN_PROG_RESET   8'h50
`define OCC_FN_CLEAR_RESET  8'h43
`define OCC_FN_PROG_LOAD    8'h4c
`define OCC_FN_STORE_SAVE   8'h53
`define OCC_FN_RESTART      8'h52
`define OCC_FN_STEP         8'h49
`define OCC_FN_RESET_STEP   8'h4e
`define OCC_FN_DISP_ALTER   8'h44
`define OCC_FN_ADDR_COMP    8'h41
`define OCC_FN_CHECK_CTL    8'h4b
`define OCC_FN_INT_TIMER    8'h4a
`define OCC_FN_NATIVE_DISP  8'h4d
`define OCC_FN_DISKETTE     8'h47
`define OCC_FN_DEV_ADDR     8'h48
`define OCC_FN_TOD_ENABLE   8'h59
`define OCC_FN_COMM_LINES   8'h45

// Function select index width
`define OCC_SEL_WIDTH       5

// Display rows sent to the printer by copy
`define OCC_COPY_FIRST_ROW  5'd1
`define OCC_COPY_LAST_ROW   5'd24
`define OCC_SCREEN_COLS     7'd80
`define OCC_SCREEN_ROWS     5'd25

`endif

// ### src/occ_console.v
`timescale 1ns/1ps
`include "occ_defs.vh"

module occ_console (
   // Clock, reset, enable
   input  wire        CLK_I,
   input  wire        ARST_N_I,
   input  wire        CE_I,
   // Register port
   input  wire [7:0]  ADDR_I,
   input  wire [31:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output wire [31:0] RDATA_O,
   // Panel pins
   input  wire        LAMP_TEST_N_I,
   input  wire        POWER_ON_I,
   input  wire        POWER_OFF_I,
   input  wire        SEQ_DONE_I,
   input  wire        BASIC_CHECK_I,
   input  wire        SP_PLUG_I,
   // Keyboard pins
   input  wire        KEY_DOWN_I,
   input  wire [6:0]  KEY_CODE_I,
   input  wire        ALT_SHIFT_I,
   // Processor status from the same clock
   input  wire        CPU_RUNNING_I,
   input  wire        METER_RUN_I,
   input  wire        CPU_WAITING_I,
   input  wire        INSTR_DONE_I,
   input  wire        IO_IDLE_I,
   input  wire        INT_PENDING_I,
   // Panel indicators
   output wire        PWR_IN_PROC_O,
   output wire        PWR_COMPLETE_O,
   output wire        BASIC_CHECK_O,
   output wire        SYSTEM_LAMP_O,
   output wire        WAIT_LAMP_O,
   output wire        CARD_LAMP_O,
   // Console control outputs
   output wire        MICROCODE_LOAD_O,
   output wire        MANUAL_BUF_SHOWN_O,
   output wire        STOP_CPU_O,
   output wire [1:0]  MENU_SHOWN_O,
   output wire [4:0]  MENU_LIST_O
);

   // Power sequencer states
   localparam [3:0] PS_OFF   = 4'b0001;
   localparam [3:0] PS_SEQ   = 4'b0010;
   localparam [3:0] PS_ON    = 4'b0100;
   localparam [3:0] PS_DOWN  = 4'b1000;

   // Synchronised pins
   reg  [10:0] sync1_q;
   reg  [10:0] sync2_q;
   reg  [6:0]  code1_q;
   reg  [6:0]  code2_q;

   // Registers
   reg  [3:0]  ctrl_q;
   reg  [2:0]  facil_q;
   reg  [7:0]  menu_sel_q;
   reg  [11:0] events_q;
   reg  [7:0]  key_last_q;
   reg  [31:0] rdata_q;
   reg  [3:0]  pstate_q;
   reg         key_prev_q;
   reg         manual_q;
   reg  [1:0]  menu_q;
   reg  [4:0]  list_q;
   reg         stop_pend_q;
   reg         stop_q;
   reg         pwr_ip_q;
   reg         pwr_ok_q;
   reg         mload_q;
   reg         lamp_sys_q;
   reg         lamp_wait_q;
   reg         lamp_chk_q;
   reg         lamp_card_q;

   // Next values
   reg  [11:0] ev_set;
   reg         manual_d;
   reg  [1:0]  menu_d;
   reg         stop_set;
   reg  [3:0]  pstate_d;

   // Synchronised pin names
   wire lamp_test = ~sync2_q[0];
   wire pwr_on    = sync2_q[1];
   wire pwr_off   = sync2_q[2];
   wire seq_done  = sync2_q[3];
   wire chk_in    = sync2_q[4];
   wire plug      = sync2_q[5];
   wire key_down  = sync2_q[6];
   wire alt_held  = sync2_q[7];

   // New key press edge, one event per press
   // Codes at or above the key count are ignored
   wire press     = key_down & ~key_prev_q;
   wire key_valid = code2_q < `OCC_KEY_COUNT;
   wire is_pf     = (code2_q >= `OCC_KEY_PF_FIRST) && (code2_q <= `OCC_KEY_PF_LAST);
   wire pkb_lock  = ctrl_q[`OCC_CTRL_PKB_EMUL] & manual_q;

   // Register write strobe for a given address
   function wr_hit;
      input [7:0] a;
      begin
         wr_hit = WR_I & (ADDR_I == a);
      end
   endfunction

   // Two-flop synchronisers for pins
   // Lamp test idles high after reset, so no false lamp flash on release
   // Key code follows the same path, so code and strobe stay aligned
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sync1_q <= 11'h001;
         sync2_q <= 11'h001;
         code1_q <= 7'h00;
         code2_q <= 7'h00;
      end else if (CE_I) begin
         sync1_q <= {3'h0, ALT_SHIFT_I, KEY_DOWN_I, SP_PLUG_I, BASIC_CHECK_I,
                     SEQ_DONE_I, POWER_OFF_I, POWER_ON_I, LAMP_TEST_N_I};
         sync2_q <= sync1_q;
         code1_q <= KEY_CODE_I;
         code2_q <= code1_q;
      end
   end

   // Key decoder
   always @* begin
      ev_set   = 12'h000;
      manual_d = manual_q;
      menu_d   = menu_q;
      stop_set = 1'b0;
      if (press && key_valid) begin
         case (code2_q)
            `OCC_KEY_MENU: begin
               manual_d = 1'b1;
               ev_set[`OCC_EV_MENU] = 1'b1;
               if (alt_held)
                  menu_d = `OCC_MENU_MAINT;
               else if (ctrl_q[`OCC_CTRL_EXT_ASSIST])
                  menu_d = `OCC_MENU_OPER_EXT;
               else
                  menu_d = `OCC_MENU_OPER_STD;
            end
            `OCC_KEY_TOGGLE: begin
               manual_d = ~manual_q;
            end
            `OCC_KEY_CANCEL: begin
               if (!pkb_lock) begin
                  if (!manual_q) begin
                     ev_set[`OCC_EV_ATTN]      = 1'b1;
                     ev_set[`OCC_EV_CANCEL_ID] = 1'b1;
                  end else begin
                     manual_d = 1'b0;
                     menu_d   = `OCC_MENU_NONE;
                     ev_set[`OCC_EV_MBUF_CLR] = 1'b1;
                  end
               end
            end
            `OCC_KEY_INTR: begin
               if (alt_held)
                  ev_set[`OCC_EV_RSF_END] = ctrl_q[`OCC_CTRL_RSF_ACTIVE];
               else
                  ev_set[`OCC_EV_EXT_INT] = 1'b1;
            end
            `OCC_KEY_ERASE: begin
               if (alt_held)
                  ev_set[`OCC_EV_SP_MAINT] = plug;
               else
                  ev_set[`OCC_EV_FIELD_ERS] = 1'b1;
            end
            `OCC_KEY_REQUEST: begin
               if (!pkb_lock) begin
                  if (alt_held)
                     ev_set[`OCC_EV_COMM_REQ] = ctrl_q[`OCC_CTRL_RSF_ACTIVE];
                  else
                     ev_set[`OCC_EV_ATTN] = ~manual_q;
               end
            end
            `OCC_KEY_COPY: begin
               ev_set[`OCC_EV_COPY] = manual_q & ctrl_q[`OCC_CTRL_COPY_PRINTER];
            end
            // Stop only arms a request; the halt waits for a quiet processor
            `OCC_KEY_STOP: begin
               stop_set = 1'b1;
            end
            default: begin
               ev_set[`OCC_EV_PFKEY] = is_pf & ~pkb_lock;
            end
         endcase
      end
   end

   // Key state, screen mode, events
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         key_prev_q <= 1'b0;
         key_last_q <= 8'h00;
         manual_q   <= 1'b0;
         menu_q     <= `OCC_MENU_NONE;
         events_q   <= 12'h000;
      end else if (CE_I) begin
         key_prev_q <= key_down;
         if (press && key_valid)
            key_last_q <= {alt_held, code2_q};
         manual_q <= manual_d;
         // Menu closes whenever the system buffer is shown
         menu_q   <= manual_d ? menu_d : `OCC_MENU_NONE;
         // Set wins over a write-one clear
         if (wr_hit(`OCC_ADDR_EVENTS))
            events_q <= (events_q & ~WDATA_I[11:0]) | ev_set;
         else
            events_q <= events_q | ev_set;
      end
   end

   // Menu listing
   // Listing follows control and facility bits one cycle later
   // Device address entry goes with the diskette facility
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         list_q <= 5'h00;
      end else if (CE_I) begin
         list_q[`OCC_LIST_STORE_STATUS] <= ~ctrl_q[`OCC_CTRL_EXT_ASSIST];
         list_q[`OCC_LIST_MACHINE_SAVE] <= ctrl_q[`OCC_CTRL_EXT_ASSIST];
         list_q[`OCC_LIST_DISKETTE]     <= facil_q[`OCC_FAC_DISKETTE];
         list_q[`OCC_LIST_DEV_ADDR]     <= facil_q[`OCC_FAC_DISKETTE];
         list_q[`OCC_LIST_COMM]         <= facil_q[`OCC_FAC_COMM];
      end
   end

   // Stop request held until processor is quiet
   // A new stop press while one waits merges into the same request
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         stop_pend_q <= 1'b0;
         stop_q      <= 1'b0;
      end else if (CE_I) begin
         if (stop_pend_q && INSTR_DONE_I && IO_IDLE_I && !INT_PENDING_I) begin
            stop_pend_q <= 1'b0;
            stop_q      <= 1'b1;
         end else begin
            stop_pend_q <= stop_pend_q | stop_set;
            stop_q      <= 1'b0;
         end
      end
   end

   // Power sequencer
   // Down state waits for both power pins low before a new power-on
   always @* begin
      pstate_d = pstate_q;
      case (pstate_q)
         PS_OFF:  if (pwr_on) pstate_d = PS_SEQ;
         PS_SEQ:  if (pwr_off) pstate_d = PS_DOWN;
                  else if (seq_done) pstate_d = PS_ON;
         PS_ON:   if (pwr_off) pstate_d = PS_DOWN;
         PS_DOWN: if (!pwr_on && !pwr_off) pstate_d = PS_OFF;
         default: pstate_d = PS_OFF;
      endcase
   end

   // Power state and indicators
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pstate_q    <= PS_OFF;
         pwr_ip_q    <= 1'b0;
         pwr_ok_q    <= 1'b0;
         mload_q     <= 1'b0;
         lamp_sys_q  <= 1'b0;
         lamp_wait_q <= 1'b0;
         lamp_chk_q  <= 1'b0;
         lamp_card_q <= 1'b0;
      end else if (CE_I) begin
         pstate_q <= pstate_d;
         // Microcode load pulse as sequencing ends
         mload_q  <= (pstate_q == PS_SEQ) && (pstate_d == PS_ON);
         // Lamp test forces each lamp on while held, the card lamp only when the card unit is fitted
         pwr_ip_q <= lamp_test | (pstate_d == PS_SEQ) | (pstate_d == PS_DOWN);
         pwr_ok_q <= lamp_test | (pstate_d == PS_ON);
         lamp_sys_q  <= lamp_test | (CPU_RUNNING_I & METER_RUN_I);
         lamp_wait_q <= lamp_test | CPU_WAITING_I;
         lamp_chk_q  <= lamp_test | chk_in;
         lamp_card_q <= lamp_test & facil_q[`OCC_FAC_CARD_UNIT];
      end
   end

   // Register writes
   // Unmapped addresses fall through and are ignored
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ctrl_q     <= 4'h0;
         facil_q    <= 3'h0;
         menu_sel_q <= 8'h00;
      end else if (CE_I) begin
         if (wr_hit(`OCC_ADDR_CTRL))
            ctrl_q <= WDATA_I[3:0];
         if (wr_hit(`OCC_ADDR_FACIL))
            facil_q <= WDATA_I[2:0];
         // Function chosen by one character code
         if (wr_hit(`OCC_ADDR_MENUSEL))
            menu_sel_q <= WDATA_I[7:0];
      end
   end

   // Register reads, data in the following cycle
   // Idle cycles return zero so the read bus can be merged by OR
   always @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rdata_q <= 32'h0000_0000;
      end else if (CE_I) begin
         if (RD_I) begin
            case (ADDR_I)
               `OCC_ADDR_CTRL:    rdata_q <= {28'h0, ctrl_q};
               `OCC_ADDR_STATUS:  rdata_q <= {20'h0, list_q, menu_q, stop_pend_q,
                                              manual_q, pwr_ok_q, pwr_ip_q, pstate_q[0]};
               `OCC_ADDR_KEYEV:   rdata_q <= {24'h0, key_last_q};
               `OCC_ADDR_MENUSEL: rdata_q <= {24'h0, menu_sel_q};
               `OCC_ADDR_EVENTS:  rdata_q <= {20'h0, events_q};
               `OCC_ADDR_FACIL:   rdata_q <= {29'h0, facil_q};
               default:           rdata_q <= 32'h0000_0000;
            endcase
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // Outputs
   // Every output comes straight from a flip-flop
   assign RDATA_O            = rdata_q;
   assign PWR_IN_PROC_O      = pwr_ip_q;
   assign PWR_COMPLETE_O     = pwr_ok_q;
   assign BASIC_CHECK_O      = lamp_chk_q;
   assign SYSTEM_LAMP_O      = lamp_sys_q;
   assign WAIT_LAMP_O        = lamp_wait_q;
   assign CARD_LAMP_O        = lamp_card_q;
   assign MICROCODE_LOAD_O   = mload_q;
   assign MANUAL_BUF_SHOWN_O = manual_q;
   assign STOP_CPU_O         = stop_q;
   assign MENU_SHOWN_O       = menu_q;
   assign MENU_LIST_O        = list_q;

endmodule

// ### tb/occ_console_checker.sv
`timescale 1ns/1ps
`include "occ_defs.vh"

module occ_console_checker (
   // Clock and reset
   input wire        CLK_I,
   input wire        ARST_N_I,
   input wire        CE_I,
   // Register port
   input wire        RD_I,
   input wire [31:0] RDATA_O,
   // Pins and processor status
   input wire        LAMP_TEST_N_I,
   input wire        CPU_RUNNING_I,
   input wire        METER_RUN_I,
   input wire        CPU_WAITING_I,
   input wire        INSTR_DONE_I,
   input wire        IO_IDLE_I,
   input wire        INT_PENDING_I,
   // Outputs watched
   input wire        PWR_IN_PROC_O,
   input wire        PWR_COMPLETE_O,
   input wire        BASIC_CHECK_O,
   input wire        SYSTEM_LAMP_O,
   input wire        WAIT_LAMP_O,
   input wire        MICROCODE_LOAD_O,
   input wire        STOP_CPU_O,
   input wire [1:0]  MENU_SHOWN_O,
   input wire [4:0]  MENU_LIST_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   // Lamps follow processor state one cycle later
   a_system_lamp: assert property (CE_I && CPU_RUNNING_I && METER_RUN_I |=> SYSTEM_LAMP_O)
      else $error("system lamp dark while running");
   a_system_dark: assert property (LAMP_TEST_N_I [*4] ##0 (CE_I && !CPU_RUNNING_I)
      |=> !SYSTEM_LAMP_O) else $error("system lamp lit while not running");
   a_wait_lamp: assert property (CE_I && CPU_WAITING_I |=> WAIT_LAMP_O)
      else $error("wait lamp dark while waiting");
   a_lamp_test: assert property (!LAMP_TEST_N_I [*4] ##0 CE_I |=> PWR_IN_PROC_O &&
      PWR_COMPLETE_O && BASIC_CHECK_O && SYSTEM_LAMP_O && WAIT_LAMP_O)
      else $error("lamp test left a lamp dark");
   // Stop only once the processor is quiet
   a_stop_cause: assert property (STOP_CPU_O |-> $past(INSTR_DONE_I) && $past(IO_IDLE_I)
      && !$past(INT_PENDING_I)) else $error("stop issued while busy");
   a_stop_pulse: assert property (STOP_CPU_O |=> !STOP_CPU_O)
      else $error("stop pulse too long");
   // Microcode load comes with the power lamps swapped
   a_load_pulse: assert property (MICROCODE_LOAD_O |=> !MICROCODE_LOAD_O)
      else $error("load pulse too long");
   a_load_power: assert property (MICROCODE_LOAD_O |-> ##[0:1]
      (PWR_COMPLETE_O && !PWR_IN_PROC_O)) else $error("load without power complete");
   // Read data only in the cycle after a read
   a_rdata_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
      else $error("read data outside read slot");
   // Menu variant lists the right save function
   a_menu_std: assert property (MENU_SHOWN_O == `OCC_MENU_OPER_STD |->
      MENU_LIST_O[1:0] == 2'h1) else $error("standard menu list wrong");
   a_menu_ext: assert property (MENU_SHOWN_O == `OCC_MENU_OPER_EXT |->
      MENU_LIST_O[1:0] == 2'h2) else $error("extended menu list wrong");
endmodule

bind occ_console occ_console_checker i_chk (.CLK_I, .ARST_N_I, .CE_I, .RD_I, .RDATA_O,
   .LAMP_TEST_N_I, .CPU_RUNNING_I, .METER_RUN_I, .CPU_WAITING_I, .INSTR_DONE_I,
   .IO_IDLE_I, .INT_PENDING_I, .PWR_IN_PROC_O, .PWR_COMPLETE_O, .BASIC_CHECK_O,
   .SYSTEM_LAMP_O, .WAIT_LAMP_O, .MICROCODE_LOAD_O, .STOP_CPU_O, .MENU_SHOWN_O,
   .MENU_LIST_O);

// ### tb/occ_operator.sv
`timescale 1ns/1ps

module occ_operator (
   // Clock
   input  wire       clk_i,
   // Keyboard lines
   output reg        key_down_o,
   output reg  [6:0] key_code_o,
   output reg        alt_shift_o
);
   // Keyboard idle at start
   initial begin
      key_down_o  = 1'b0;
      key_code_o  = 7'h7f;
      alt_shift_o = 1'b0;
   end

   // One press: shift first, key held, then released with a quiet gap
   task press(input logic alternate_shift_key, input logic [6:0] code, input int hold);
      @(posedge clk_i);
      alt_shift_o <= alternate_shift_key;
      key_code_o  <= code;
      @(posedge clk_i);
      key_down_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      key_down_o <= 1'b0;
      @(posedge clk_i);
      key_code_o  <= ~code;
      alt_shift_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// ### tb/tb_occ_console.sv
`timescale 1ns/1ps
`include "occ_defs.vh"

module tb_occ_console;
   typedef struct packed {
      logic [3:0]  c;
      logic        a, p, m;
      logic [6:0]  k;
      logic [11:0] e;
   } occ_kcase_t;
   typedef struct packed {
      logic [3:0]  c;
      logic        a;
      logic [2:0]  f;
      logic [1:0]  mn;
      logic [4:0]  l;
   } occ_mcase_t;
   logic clk = 0, rst_n = 0, ce = 1, wr_s = 0, rd_s = 0, lt_n = 1, pon = 0, poff = 0;
   logic sdone = 0, bchk = 0, plug = 0, run = 0, meter = 0, waiting = 0;
   logic idone = 0, ioidle = 0, intp = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   wire [31:0] rdata;
   wire pip, pcomp, bco, sysl, waitl, cardl, uload, manual, stopc, kd, alternate_shift_key;
   wire [1:0] menu;
   wire [4:0] mlist;
   wire [6:0] kc;
   int n_errors = 0, comparisons = 0, n_load = 0, n_stop = 0;
   occ_kcase_t kt [17] = '{
      '{4'h0, 0, 0, 0, `OCC_KEY_CANCEL, 12'h005},
      '{4'h0, 0, 0, 1, `OCC_KEY_CANCEL, 12'h200},
      '{4'h0, 0, 0, 0, `OCC_KEY_INTR, 12'h002},
      '{4'h8, 1, 0, 0, `OCC_KEY_INTR, 12'h008},
      '{4'h0, 1, 0, 0, `OCC_KEY_ERASE, 12'h000},
      '{4'h0, 1, 1, 0, `OCC_KEY_ERASE, 12'h020},
      '{4'h0, 0, 1, 0, `OCC_KEY_ERASE, 12'h100},
      '{4'h0, 0, 0, 0, `OCC_KEY_REQUEST, 12'h001},
      '{4'h0, 0, 0, 1, `OCC_KEY_REQUEST, 12'h000},
      '{4'h8, 1, 0, 0, `OCC_KEY_REQUEST, 12'h010},
      '{4'h4, 0, 0, 0, `OCC_KEY_COPY, 12'h000},
      '{4'h4, 0, 0, 1, `OCC_KEY_COPY, 12'h040},
      '{4'h2, 0, 0, 1, `OCC_KEY_CANCEL, 12'h000},
      '{4'h2, 0, 0, 1, `OCC_KEY_PF_FIRST, 12'h000},
      '{4'h0, 0, 0, 0, `OCC_KEY_PF_LAST, 12'h400},
      '{4'h0, 0, 0, 0, `OCC_KEY_COUNT, 12'h000},
      '{4'h0, 0, 0, 0, `OCC_KEY_MENU, 12'h800}};
   occ_mcase_t mt [4] = '{
      '{4'h0, 0, 3'h3, `OCC_MENU_OPER_STD, 5'h1d},
      '{4'h1, 0, 3'h3, `OCC_MENU_OPER_EXT, 5'h1e},
      '{4'h0, 0, 3'h0, `OCC_MENU_OPER_STD, 5'h01},
      '{4'h0, 1, 3'h3, `OCC_MENU_MAINT, 5'h00}};
   logic [7:0] fn [3] = '{`OCC_FN_PROG_RESET, `OCC_FN_CLEAR_RESET, `OCC_FN_PROG_LOAD};

   occ_console i_dut (.CLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .LAMP_TEST_N_I(lt_n),
      .POWER_ON_I(pon), .POWER_OFF_I(poff), .SEQ_DONE_I(sdone), .BASIC_CHECK_I(bchk),
      .SP_PLUG_I(plug), .KEY_DOWN_I(kd), .KEY_CODE_I(kc), .ALT_SHIFT_I(alternate_shift_key),
      .CPU_RUNNING_I(run), .METER_RUN_I(meter), .CPU_WAITING_I(waiting),
      .INSTR_DONE_I(idone), .IO_IDLE_I(ioidle), .INT_PENDING_I(intp),
      .PWR_IN_PROC_O(pip), .PWR_COMPLETE_O(pcomp), .BASIC_CHECK_O(bco),
      .SYSTEM_LAMP_O(sysl), .WAIT_LAMP_O(waitl), .CARD_LAMP_O(cardl),
      .MICROCODE_LOAD_O(uload), .MANUAL_BUF_SHOWN_O(manual), .STOP_CPU_O(stopc),
      .MENU_SHOWN_O(menu), .MENU_LIST_O(mlist));
   occ_operator i_op (.clk_i(clk), .key_down_o(kd), .key_code_o(kc), .alt_shift_o(alternate_shift_key));

   // Clock and pulse counters
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (uload === 1'b1) n_load++;
      if (stopc === 1'b1) n_stop++;
   end

   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(n, rdata, e);
   endtask
   task settle;
      repeat (8) @(posedge clk);
   endtask
   task complete_run;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (50000) @(posedge clk);
      n_errors++;
      complete_run;
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Power on, sequencing, microcode load
      pon <= 1'b1;
      settle;
      chk("in process", pip, 1);
      chk("complete early", pcomp, 0);
      sdone <= 1'b1;
      settle;
      chk("in process off", pip, 0);
      chk("complete", pcomp, 1);
      chk("load pulses", n_load, 1);
      // Registers, unmapped place, dropped access
      rd(`OCC_ADDR_EVENTS, 32'h0, "events reset");
      rd(`OCC_ADDR_CTRL, 32'h0, "ctrl reset");
      foreach (fn[i]) begin
         wr(`OCC_ADDR_MENUSEL, {24'h0, fn[i]});
         rd(`OCC_ADDR_MENUSEL, {24'h0, fn[i]}, "function code");
      end
      wr(8'h18, 32'hffffffff);
      rd(8'h18, 32'h0, "unmapped");
      ce <= 1'b0;
      wr(`OCC_ADDR_MENUSEL, 32'h53);
      ce <= 1'b1;
      rd(`OCC_ADDR_MENUSEL, {24'h0, `OCC_FN_PROG_LOAD}, "dropped write");
      // Lamp test with card unit fitted, then processor lamps
      wr(`OCC_ADDR_FACIL, 32'h4);
      lt_n <= 1'b0;
      settle;
      chk("lamps", {pip, pcomp, bco, sysl, waitl, cardl}, 6'h3f);
      lt_n <= 1'b1;
      run <= 1'b1;
      meter <= 1'b1;
      bchk <= 1'b1;
      settle;
      chk("lamps run", {cardl, sysl, waitl, bco}, 4'h5);
      meter <= 1'b0;
      waiting <= 1'b1;
      settle;
      chk("lamps wait", {sysl, waitl}, 2'h1);
      // Menu variants and listings
      foreach (mt[i]) begin
         wr(`OCC_ADDR_CTRL, {28'h0, mt[i].c});
         wr(`OCC_ADDR_FACIL, {29'h0, mt[i].f});
         i_op.press(mt[i].a, `OCC_KEY_MENU, 4);
         chk("menu", menu, mt[i].mn);
         if (mt[i].mn != `OCC_MENU_MAINT) chk("list", mlist, mt[i].l);
         chk("menu manual", manual, 1);
         i_op.press(1'b0, `OCC_KEY_TOGGLE, 4);
         chk("menu closed", {manual, menu}, 3'h0);
      end
      // Key functions by mode
      foreach (kt[i]) begin
         wr(`OCC_ADDR_CTRL, {28'h0, kt[i].c});
         plug <= kt[i].p;
         if (kt[i].m) i_op.press(1'b0, `OCC_KEY_TOGGLE, 4);
         wr(`OCC_ADDR_EVENTS, 32'hfff);
         i_op.press(kt[i].a, kt[i].k, 4);
         rd(`OCC_ADDR_EVENTS, {20'h0, kt[i].e}, "events");
         if (kt[i].k != `OCC_KEY_COUNT)
            rd(`OCC_ADDR_KEYEV, {24'h0, kt[i].a, kt[i].k}, "key seen");
         if (manual === 1'b1) i_op.press(1'b0, `OCC_KEY_TOGGLE, 4);
      end
      i_op.press(1'b0, `OCC_KEY_TOGGLE, 3);
      chk("manual shown", manual, 1);
      i_op.press(1'b0, `OCC_KEY_CANCEL, 3);
      chk("back to system", manual, 0);
      // Stop held long, waits for a quiet processor
      ioidle <= 1'b1;
      i_op.press(1'b0, `OCC_KEY_STOP, 30);
      chk("stop early", n_stop, 0);
      idone <= 1'b1;
      intp  <= 1'b1;
      settle;
      chk("stop on interrupt", n_stop, 0);
      intp <= 1'b0;
      settle;
      chk("stop pulses", n_stop, 1);
      // Power off
      poff <= 1'b1;
      settle;
      chk("power off", pip, 1);
      chk("complete off", pcomp, 0);
      rd(`OCC_ADDR_STATUS, 32'h0000_0e82, "status");
      complete_run;
   end
endmodule
